/* File: rtc_pkg.sv */
// Purpose: Shared constants for the prescaler, wakeup and shift block
// Assumes: Byte registers on word-aligned AHB addresses (index * 4)
// Notes: Indices are register numbers, not byte addresses
package rtc_pkg;
   localparam logic [7:0] IDX_CTRL = 8'h08;
   localparam logic [7:0] IDX_STAT = 8'h0C;
   localparam logic [7:0] IDX_SYNC_HI = 8'h10;
   localparam logic [7:0] IDX_SYNC_LO = 8'h11;
   localparam logic [7:0] IDX_ASYNC = 8'h12;
   localparam logic [7:0] IDX_WU_HI = 8'h14;
   localparam logic [7:0] IDX_WU_LO = 8'h15;
   localparam logic [7:0] IDX_KEY = 8'h19;
   localparam logic [7:0] IDX_SHIFT_HI = 8'h1A;
   localparam logic [7:0] IDX_SHIFT_LO = 8'h1B;
   localparam logic [7:0] IDX_ALARM_SEC = 8'h1C;
   // Control fields
   localparam int CT_INIT = 7;
   localparam int CT_AL_EN = 4;
   localparam int CT_WU_EN = 3;
   localparam int CT_WUSEL = 0;
   // Status fields
   localparam int ST_WU_FLAG = 8;
   localparam int ST_INIT_OK = 6;
   localparam int ST_SHIFT = 3;
   localparam int ST_WU_WR = 2;
   localparam int ST_AL_WR = 0;
   // Shift high byte fields
   localparam int SH_ADD_ONE_SECOND = 7;
   // Alarm seconds fields
   localparam int AL_MASK = 7;
   // Power-on values; CTRL_RST is the system reset value
   localparam logic [6:0] SYNC_HI_POR = 7'h00;
   localparam logic [7:0] SYNC_LO_POR = 8'hFF;
   localparam logic [6:0] ASYNC_POR = 7'h7F;
   localparam logic [15:0] WU_POR = 16'hFFFF;
   localparam logic [7:0] ALARM_POR = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Wakeup clock selections
   localparam logic [2:0] WUSEL_DIV16 = 3'h0;
   localparam logic [2:0] WUSEL_DIV8 = 3'h1;
   localparam logic [2:0] WUSEL_DIV4 = 3'h2;
   localparam logic [2:0] WUSEL_DIV2 = 3'h3;
   typedef enum logic [2:0] {
      KEY_LOCKED = 3'b001,
      KEY_HALF = 3'b010,
      KEY_OPEN = 3'b100
   } key_state_t;
endpackage

/* File: rtc_prescaler_wakeup_shift.sv */
// Purpose: Prescalers, wakeup timer, key lock, shift and alarm seconds
// Assumes: Low-speed clock arrives as a pin, far slower than hclk
// Notes: AHB-Lite slave; writes zero-wait, reads one wait state
// Contract
// - Second tick equals async ticks over sync+1
// - Sync bits 14:13 only on large variants
// - Prescaler writes only while init allowed
// - Async divides low-speed clock by factor+1
// - Prescaler/wakeup keep values across system reset
// - Wakeup flag every reload+1 wakeup ticks
// - First wakeup flag reload+1 ticks after enable
// - Reload writes need enable clear, flag set
// - Key register write-only, reads zero
// - Add-second write-only, applied on low write
// - Shift writes ignored while shift pending
// - Shift adds fraction to sync counter
// - Add-second with fraction advances one second
// - Fraction bits read back as zero
// - Seconds mask bit excludes seconds compare
// - Alarm seconds held as BCD tens/units
// - Alarm writes in init or enable clear
// - Protected writes need key unlock first
// - Init flag rises only once in init
// - Shift pending set on trigger, auto-cleared
module rtc_prescaler_wakeup_shift #(
   parameter bit LARGE_DENSITY = 1'b1,
   parameter logic [7:0] KEY_FIRST = 8'hA5,  // Arbitrary value
   parameter logic [7:0] KEY_SECOND = 8'h5A  // Arbitrary value
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic por_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic low_speed_input_clock,
   input wire logic [6:0] current_seconds,
   output logic second_tick_clock,
   output logic [15:0] sync_count,
   output logic wakeup_flag,
   output logic alarm_seconds_match,
   output logic shift_pending,
   output logic init_allowed_flag
);
   import rtc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic ap_wr_reg, ap_rd_reg, rd_done_reg;
   logic [7:0] ap_idx_reg;
   logic [31:0] rd_next;
   logic [7:0] wd;
   logic unlocked;
   key_state_t key_reg;
   logic [7:0] ctrl_reg;
   logic [6:0] sync_hi_reg;
   logic [7:0] sync_lo_reg;
   logic [6:0] async_reg;
   logic [15:0] wu_reload_reg;
   logic [7:0] alarm_reg;
   logic [7:0] shift_hi_reg;
   logic [7:0] shift_lo_reg;
   logic wu_wr_ok_reg, al_wr_ok_reg, init_ok_reg;
   logic ls_s1, ls_s2, ls_s3, ls_lvl_reg, ls_tick;
   logic [6:0] async_cnt_reg;
   logic apre_tick_reg;
   logic [15:0] sync_cnt_reg;
   logic [3:0] ls_div_reg;
   logic wu_tick;
   logic [15:0] wu_cnt_reg;
   logic wu_flag_reg, wu_hit;
   logic [14:0] sync_mask;

   function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                   input logic [7:0] b);
      wr_hit = en && (a == b);
   endfunction

   assign wd = hwdata[7:0];
   assign unlocked = (key_reg == KEY_OPEN);
   assign sync_mask = LARGE_DENSITY ? 15'h7FFF : 15'h1FFF;

   ////////////////////////////////////////////////////////////////////
   // AHB-Lite: reads stall one cycle so the mux sees settled registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_wr_reg <= 1'b0;
         ap_rd_reg <= 1'b0;
         ap_idx_reg <= 8'h00;
      end
      else if (hready)
      begin
         ap_wr_reg <= hsel && htrans[1] && hwrite;
         ap_rd_reg <= hsel && htrans[1] && !hwrite;
         ap_idx_reg <= haddr[9:2];
      end
      else
      begin
         ap_wr_reg <= 1'b0;
         ap_rd_reg <= ap_rd_reg && rd_done_reg ? 1'b0 : ap_rd_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_done_reg <= 1'b0;
         hrdata <= 32'h0000_0000;
      end
      else if (ap_rd_reg && !rd_done_reg)
      begin
         rd_done_reg <= 1'b1;
         hrdata <= rd_next;
      end
      else
         rd_done_reg <= 1'b0;
   end

   assign hreadyout = !(ap_rd_reg && !rd_done_reg);
   assign hresp = 1'b0;

   always_comb
   begin
      rd_next = 32'h0000_0000;
      case (ap_idx_reg)
         IDX_CTRL: rd_next = {24'h0, ctrl_reg};
         IDX_STAT: rd_next = {23'h0, wu_flag_reg, 1'b0, init_ok_reg, 2'b0,
                              shift_pending, wu_wr_ok_reg, 1'b0, al_wr_ok_reg};
         IDX_SYNC_HI: rd_next = {25'h0, sync_hi_reg & sync_mask[14:8]};
         IDX_SYNC_LO: rd_next = {24'h0, sync_lo_reg};
         IDX_ASYNC: rd_next = {25'h0, async_reg};
         IDX_WU_HI: rd_next = {24'h0, wu_reload_reg[15:8]};
         IDX_WU_LO: rd_next = {24'h0, wu_reload_reg[7:0]};
         IDX_ALARM_SEC: rd_next = {24'h0, alarm_reg};
         // Key and shift bytes fall through to zero
         default: rd_next = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Key lock: two ordered keys open, any other key closes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         key_reg <= KEY_LOCKED;
      else if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_KEY))
      begin
         case (key_reg)
            KEY_LOCKED: key_reg <= (wd == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
            KEY_HALF: key_reg <= (wd == KEY_SECOND) ? KEY_OPEN : KEY_LOCKED;
            KEY_OPEN: key_reg <= KEY_LOCKED;
            default: key_reg <= KEY_LOCKED;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_reg <= CTRL_RST;
      else if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_CTRL) && unlocked)
         ctrl_reg <= wd;
   end

   ////////////////////////////////////////////////////////////////////
   // Power-on domain: a system reset leaves these alone
   always_ff @(posedge hclk or negedge por_n)
   begin
      if (!por_n)
      begin
         sync_hi_reg <= SYNC_HI_POR;
         sync_lo_reg <= SYNC_LO_POR;
         async_reg <= ASYNC_POR;
      end
      else if (unlocked && init_ok_reg)
      begin
         if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_SYNC_HI))
            sync_hi_reg <= wd[6:0] & sync_mask[14:8];
         if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_SYNC_LO))
            sync_lo_reg <= wd;
         if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_ASYNC))
            async_reg <= wd[6:0];
      end
   end

   always_ff @(posedge hclk or negedge por_n)
   begin
      if (!por_n)
         wu_reload_reg <= WU_POR;
      else if (unlocked && !ctrl_reg[CT_WU_EN] && wu_wr_ok_reg)
      begin
         if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_WU_HI))
            wu_reload_reg[15:8] <= wd;
         if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_WU_LO))
            wu_reload_reg[7:0] <= wd;
      end
   end

   always_ff @(posedge hclk or negedge por_n)
   begin
      if (!por_n)
         alarm_reg <= ALARM_POR;
      else if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_ALARM_SEC) && unlocked &&
               (init_ok_reg || (!ctrl_reg[CT_AL_EN] && al_wr_ok_reg)))
         alarm_reg <= wd;
   end

   assign alarm_seconds_match = alarm_reg[AL_MASK] || (current_seconds == alarm_reg[6:0]);

   ////////////////////////////////////////////////////////////////////
   // Write-allowed flags follow the enables one cycle later
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wu_wr_ok_reg <= 1'b0;
         al_wr_ok_reg <= 1'b0;
      end
      else
      begin
         wu_wr_ok_reg <= !ctrl_reg[CT_WU_EN];
         al_wr_ok_reg <= !ctrl_reg[CT_AL_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin synchroniser; stage one feeds stage two only
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ls_s1 <= 1'b0;
         ls_s2 <= 1'b0;
         ls_s3 <= 1'b0;
         ls_lvl_reg <= 1'b0;
      end
      else
      begin
         ls_s1 <= low_speed_input_clock;
         ls_s2 <= ls_s1;
         ls_s3 <= ls_s2;
         if (ls_s2 == ls_s3)
            ls_lvl_reg <= ls_s3;
      end
   end

   // Level moves only once stages two and three agree
   assign ls_tick = ls_s2 && ls_s3 && !ls_lvl_reg;

   // Init flag waits for a low-speed edge, as the counters do
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         init_ok_reg <= 1'b0;
      else if (!ctrl_reg[CT_INIT])
         init_ok_reg <= 1'b0;
      else if (ls_tick)
         init_ok_reg <= 1'b1;
   end

   assign init_allowed_flag = init_ok_reg;

   ////////////////////////////////////////////////////////////////////
   // Asynchronous prescaler
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         async_cnt_reg <= ASYNC_POR;
         apre_tick_reg <= 1'b0;
      end
      else if (ctrl_reg[CT_INIT])
      begin
         async_cnt_reg <= async_reg;
         apre_tick_reg <= 1'b0;
      end
      else
      begin
         apre_tick_reg <= ls_tick && (async_cnt_reg == 7'h00);
         if (ls_tick)
            async_cnt_reg <= (async_cnt_reg == 7'h00) ? async_reg :
                             async_cnt_reg - 7'h01;
      end
   end

   // Synchronous prescaler with shift; bit 15 catches shift overflow
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync_cnt_reg <= {1'b0, SYNC_HI_POR, SYNC_LO_POR};
         second_tick_clock <= 1'b0;
         shift_pending <= 1'b0;
      end
      else
      begin
         second_tick_clock <= 1'b0;
         if (ctrl_reg[CT_INIT])
            sync_cnt_reg <= {1'b0, sync_hi_reg & sync_mask[14:8], sync_lo_reg};
         else if (apre_tick_reg && shift_pending)
         begin
            sync_cnt_reg <= sync_cnt_reg + {1'b0, shift_hi_reg[6:0], shift_lo_reg};
            second_tick_clock <= shift_hi_reg[SH_ADD_ONE_SECOND];
         end
         else if (apre_tick_reg)
         begin
            second_tick_clock <= (sync_cnt_reg == 16'h0000);
            sync_cnt_reg <= (sync_cnt_reg == 16'h0000) ?
                            {1'b0, sync_hi_reg & sync_mask[14:8], sync_lo_reg} :
                            sync_cnt_reg - 16'h0001;
         end
         if (apre_tick_reg && shift_pending && !ctrl_reg[CT_INIT])
            shift_pending <= 1'b0;
         else if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_SHIFT_LO) && unlocked)
            shift_pending <= 1'b1;
      end
   end

   assign sync_count = sync_cnt_reg;

   // Shift bytes frozen while a shift waits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         shift_hi_reg <= 8'h00;
         shift_lo_reg <= 8'h00;
      end
      else if (unlocked && !shift_pending)
      begin
         if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_SHIFT_HI))
            shift_hi_reg <= wd;
         if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_SHIFT_LO))
            shift_lo_reg <= wd;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Wakeup clock: low-speed divided, or the one-second tick
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ls_div_reg <= 4'h0;
      else if (ls_tick)
         ls_div_reg <= ls_div_reg + 4'h1;
   end

   always_comb
   begin
      wu_tick = 1'b0;
      case (ctrl_reg[CT_WUSEL +: 3])
         WUSEL_DIV16: wu_tick = ls_tick && (ls_div_reg == 4'hF);
         WUSEL_DIV8: wu_tick = ls_tick && (ls_div_reg[2:0] == 3'h7);
         WUSEL_DIV4: wu_tick = ls_tick && (ls_div_reg[1:0] == 2'h3);
         WUSEL_DIV2: wu_tick = ls_tick && ls_div_reg[0];
         default: wu_tick = second_tick_clock;
      endcase
   end

   assign wu_hit = ctrl_reg[CT_WU_EN] && wu_tick && (wu_cnt_reg == 16'h0000);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wu_cnt_reg <= WU_POR;
      else if (!ctrl_reg[CT_WU_EN])
         wu_cnt_reg <= wu_reload_reg;
      else if (wu_tick)
         wu_cnt_reg <= (wu_cnt_reg == 16'h0000) ? wu_reload_reg :
                       wu_cnt_reg - 16'h0001;
   end

   // Set beats a same-cycle clear so no wakeup is lost
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wu_flag_reg <= 1'b0;
      else if (wu_hit)
         wu_flag_reg <= 1'b1;
      else if (wr_hit(ap_wr_reg, ap_idx_reg, IDX_STAT) && !hwdata[ST_WU_FLAG])
         wu_flag_reg <= 1'b0;
   end

   assign wakeup_flag = wu_flag_reg;

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_key_relock: assert property (
      wr_hit(ap_wr_reg, ap_idx_reg, IDX_KEY) &&
      (key_reg == KEY_OPEN || (key_reg == KEY_LOCKED && wd != KEY_FIRST))
      |=> key_reg == KEY_LOCKED)
      else $error("wrong key did not keep lock");
   chk_key_reads: assert property (
      ap_rd_reg && ap_idx_reg == IDX_KEY |-> ##1 hrdata == 32'h0)
      else $error("key read not zero");
   chk_presc_guard: assert property (
      (wr_hit(ap_wr_reg, ap_idx_reg, IDX_SYNC_LO) ||
       wr_hit(ap_wr_reg, ap_idx_reg, IDX_ASYNC)) && !init_ok_reg
      |=> $stable(sync_lo_reg) && $stable(async_reg))
      else $error("prescaler written outside init");
   chk_wu_guard: assert property (
      ctrl_reg[CT_WU_EN] |=> $stable(wu_reload_reg))
      else $error("reload changed while enabled");
   chk_wu_reload: assert property (
      wu_hit |=> wu_flag_reg && wu_cnt_reg == $past(wu_reload_reg))
      else $error("wakeup flag or reload wrong");
   chk_shift_set: assert property (
      wr_hit(ap_wr_reg, ap_idx_reg, IDX_SHIFT_LO) && unlocked && !shift_pending
      |=> shift_pending)
      else $error("shift pending not raised");
   chk_shift_hold: assert property (
      shift_pending |=> $stable(shift_hi_reg) && $stable(shift_lo_reg))
      else $error("shift bytes changed while pending");
   chk_shift_add: assert property (
      apre_tick_reg && shift_pending && !ctrl_reg[CT_INIT] |=>
      sync_cnt_reg == $past(sync_cnt_reg) + {1'b0, $past(shift_hi_reg[6:0]),
      $past(shift_lo_reg)} && !shift_pending)
      else $error("shift not applied");
   chk_alarm_mask: assert property (
      alarm_reg[AL_MASK] |-> alarm_seconds_match)
      else $error("masked seconds did not match");
   chk_init_flag: assert property (
      init_ok_reg |-> ctrl_reg[CT_INIT] || $past(ctrl_reg[CT_INIT]))
      else $error("init flag outside init");

   cov_unlock: cover property (key_reg == KEY_HALF ##1 key_reg == KEY_OPEN);
   cov_wakeup: cover property (wu_hit);
   cov_shift_add_one_second: cover property (apre_tick_reg && shift_pending &&
                                    shift_hi_reg[SH_ADD_ONE_SECOND]);
   cov_second: cover property (second_tick_clock);
endmodule

/* File: rtc_prescaler_wakeup_shift_bench.sv */
// Purpose: Self-checking bench for prescalers, wakeup, key lock, shift, alarm
// Assumes: One AHB-Lite slave, hready looped back from hreadyout
// Notes: Low-speed pin toggles every 10 hclk, so one pin period is 20 hclk
module rtc_prescaler_wakeup_shift_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import rtc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic por_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic low_speed_input_clock = 1'b0;
   logic [6:0] current_seconds = 7'h00;
   logic second_tick_clock;
   logic [15:0] sync_count;
   logic wakeup_flag;
   logic alarm_seconds_match;
   logic shift_pending;
   logic init_allowed_flag;
   int fails = 0;
   int cmp_count = 0;
   int ls_div = 0;
   int ticks = 0;
   // Model of power-on contents: index and expected byte
   int por_idx[$] = '{IDX_SYNC_HI, IDX_SYNC_LO, IDX_ASYNC, IDX_WU_HI, IDX_WU_LO, IDX_KEY,
      IDX_SHIFT_HI, IDX_SHIFT_LO, IDX_ALARM_SEC, 8'h30};
   int por_val[$] = '{SYNC_HI_POR, SYNC_LO_POR, ASYNC_POR, WU_POR[15:8], WU_POR[7:0], 0, 0, 0,
      ALARM_POR, 0};
   assign hready = hreadyout;
   always #4 hclk = ~hclk;
   rtc_prescaler_wakeup_shift rtc_prescaler_wakeup_shift_i (
      .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .low_speed_input_clock(low_speed_input_clock), .current_seconds(current_seconds),
      .second_tick_clock(second_tick_clock), .sync_count(sync_count),
      .wakeup_flag(wakeup_flag), .alarm_seconds_match(alarm_seconds_match),
      .shift_pending(shift_pending), .init_allowed_flag(init_allowed_flag));
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge hclk)
   begin
      ls_div <= (ls_div == 9) ? 0 : ls_div + 1;
      if (ls_div == 9)
         low_speed_input_clock <= ~low_speed_input_clock;
      if (second_tick_clock === 1'b1)
         ticks <= ticks + 1;
   end
   task automatic complete_run();
      if (fails == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   // Master holds each phase until hready is sampled high
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'b00};
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      rd = hrdata;
      check("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] d;
      bus(1'b1, idx, {24'h0, v}, d);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      bus(1'b0, idx, 32'h0, d);
      check(nm, {24'h0, exp}, {24'h0, d[7:0]});
   endtask
   task automatic wait_lvl(ref logic s, input logic v);
      int n;
      n = 0;
      @(posedge hclk);
      while (s !== v && n < 4000)
      begin
         @(posedge hclk);
         n++;
      end
      if (n >= 4000)
         check("wait limit", 32'h0, 32'h1);
   endtask
   task automatic unlock();
      wr(IDX_KEY, 8'hA5);
      wr(IDX_KEY, 8'h5A);
   endtask
   // Trigger a shift, return counter before and at the edge pending drops
   task automatic shift_run(input logic [7:0] lo, input logic [7:0] hi_late,
      output logic [15:0] pre, output logic [15:0] sc);
      wr(IDX_SHIFT_LO, lo);
      @(posedge hclk);
      check("pending", 32'h1, {31'h0, shift_pending});
      if (hi_late != 8'h00)
         wr(IDX_SHIFT_HI, hi_late);
      pre = sync_count;
      @(posedge hclk);
      while (shift_pending === 1'b1)
      begin
         pre = sync_count;
         @(posedge hclk);
      end
      sc = sync_count;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      fails++;
      complete_run();
   end
   initial
   begin
      logic [6:0] cur;
      logic [7:0] al;
      logic [15:0] pre;
      logic [15:0] sc;
      realtime t0;
      int k;
      void'($urandom(32'h33a0d226));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge hclk);
      for (k = 0; k < por_idx.size(); k++)
         rd_chk("power-on", 8'(por_idx[k]), 8'(por_val[k]));
      wr(IDX_ALARM_SEC, 8'h12);
      rd_chk("locked alarm", IDX_ALARM_SEC, ALARM_POR);
      unlock();
      wr(IDX_ALARM_SEC, 8'h12);
      rd_chk("open alarm", IDX_ALARM_SEC, 8'h12);
      wr(IDX_KEY, 8'h00);
      wr(IDX_ALARM_SEC, 8'h34);
      rd_chk("relocked alarm", IDX_ALARM_SEC, 8'h12);
      unlock();
      wr(IDX_ASYNC, 8'h03);
      rd_chk("async outside init", IDX_ASYNC, ASYNC_POR);
      wr(IDX_CTRL, 8'h80);
      check("init flag early", 32'h0, {31'h0, init_allowed_flag});
      wait_lvl(init_allowed_flag, 1'b1);
      wr(IDX_ASYNC, 8'h83);
      rd_chk("async", IDX_ASYNC, 8'h03);
      wr(IDX_SYNC_HI, 8'hFF);
      rd_chk("sync high", IDX_SYNC_HI, 8'h7F);
      wr(IDX_SYNC_HI, 8'h00);
      wr(IDX_SYNC_LO, 8'h03);
      rd_chk("sync low", IDX_SYNC_LO, 8'h03);
      wr(IDX_CTRL, {5'h00, WUSEL_DIV2});
      wr(IDX_WU_HI, 8'h00);
      wr(IDX_WU_LO, 8'h02);
      // Four async ticks of four pin periods each
      wait_lvl(second_tick_clock, 1'b1);
      t0 = $realtime;
      wait_lvl(second_tick_clock, 1'b1);
      check("second period", 32'd320, 32'(int'(($realtime - t0) / 8)));
      wr(IDX_CTRL, {5'h01, WUSEL_DIV2});
      t0 = $realtime;
      wr(IDX_WU_LO, 8'h07);
      rd_chk("reload while enabled", IDX_WU_LO, 8'h02);
      wait_lvl(wakeup_flag, 1'b1);
      k = int'(($realtime - t0) / 8);
      check("first wakeup", 32'h1, {31'h0, k >= 80 && k <= 170});
      t0 = $realtime;
      wr(IDX_STAT, 8'h00);
      wait_lvl(wakeup_flag, 1'b1);
      check("wakeup period", 32'd120, 32'(int'(($realtime - t0) / 8)));
      // Divide-by-four select: three ticks of four pin periods
      wr(IDX_CTRL, {5'h01, WUSEL_DIV4});
      wr(IDX_STAT, 8'h00);
      wait_lvl(wakeup_flag, 1'b1);
      t0 = $realtime;
      wr(IDX_STAT, 8'h00);
      wait_lvl(wakeup_flag, 1'b1);
      check("wakeup div4", 32'd240, 32'(int'(($realtime - t0) / 8)));
      repeat (6)
      begin
         cur = {3'($urandom_range(5)), 4'($urandom_range(9))};
         al = {1'($urandom_range(1)), 3'($urandom_range(5)), 4'($urandom_range(9))};
         if ($urandom_range(1) == 1)
            al = {al[7], cur};
         current_seconds <= cur;
         wr(IDX_ALARM_SEC, al);
         rd_chk("alarm", IDX_ALARM_SEC, al);
         check("match", {31'h0, al[7] | (al[6:0] == cur)}, {31'h0, alarm_seconds_match});
      end
      wr(IDX_CTRL, {5'h03, WUSEL_DIV2});
      wr(IDX_ALARM_SEC, ~al);
      rd_chk("alarm while enabled", IDX_ALARM_SEC, al);
      wr(IDX_SHIFT_HI, 8'h00);
      // High byte written during pending must not reach the next shift
      shift_run(8'h05, 8'h7F, pre, sc);
      check("fraction added", {16'h0, pre + 16'h0005}, {16'h0, sc});
      rd_chk("shift high", IDX_SHIFT_HI, 8'h00);
      rd_chk("shift low", IDX_SHIFT_LO, 8'h00);
      shift_run(8'h00, 8'h00, pre, sc);
      check("ignored high", {16'h0, pre}, {16'h0, sc});
      wr(IDX_SHIFT_HI, 8'h80);
      k = ticks;
      shift_run(8'h00, 8'h00, pre, sc);
      @(posedge hclk);
      check("add second", 32'h1, {31'h0, ticks > k});
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk("async kept", IDX_ASYNC, 8'h03);
      rd_chk("reload kept", IDX_WU_LO, 8'h02);
      wr(IDX_ALARM_SEC, ~al);
      rd_chk("alarm kept", IDX_ALARM_SEC, al);
      complete_run();
   end
endmodule
